// ===== pei_power_event_irq.sv
// Purpose: pending flags and enable mask of the power, clock and reset unit events, over apb
// Assumes: event inputs are asynchronous levels; apb master on clk_sys
// Notes:   enable and pending registers are read only; separate ports set and clear them
//
// What this block does
// - enable view at 0xA3, read only, resets zero
// - pending flags at 0xA4, read only, reset zero
// - bit 8 is OR of pin events 0-3
// - adc channels 0-7 land on bits 9-16
// - bit 18 pmu thermal warning, both edges
// - bit 17 front end thermal, both edges
// - bit 20 carries standby prevention event
// - reserved flag bits read zero, ignore writes
// - power events share positions in both registers
// - writing one at 0xA1 sets flag
// - writing one at 0xA2 clears flag
// - writing one at 0xA5 sets enable bit
// - writing one at 0xA6 clears enable bit
`timescale 1ns/10ps
`include "pei_cfg.svh"

module pei_power_event_irq
  import pei_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`PEI_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // event sources, asynchronous levels
  input  wire logic [3:0]              pin_event_in,
  input  wire logic [7:0]              general_adc_event_in,
  input  wire logic                    front_end_thermal_warning_in,
  input  wire logic                    pmu_thermal_warning_in,
  input  wire logic                    battery_monitor_two_low_in,
  input  wire logic                    standby_prevent_in,
  input  wire logic                    low_power_detect_in,
  input  wire logic                    bus_power_present_in,
  input  wire logic                    transmitter_supply_good_in,
  input  wire logic                    overcurrent_in,
  input  wire logic                    transmitter_regulator_overcurrent_in,
  input  wire logic                    suspend_prevent_in,
  input  wire logic                    suspend_in,
  input  wire logic                    io_supply_good_in,
  // interrupt request, level
  output logic                         irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0] raw_w;
  logic [31:0] sync1_r;
  logic [31:0] sync2_r;
  logic [31:0] prev_r;
  logic [31:0] edge_w;
  logic [31:0] evt_w;
  logic [31:0] flag_r;
  logic [31:0] flag_nxt;
  logic [31:0] en_r;
  logic [31:0] en_nxt;
  logic [31:0] wdata_valid_w;
  logic [31:0] clr_only_w;
  logic [31:0] rdata_w;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        irq_r;
  logic        any_w;
  logic        setup_w;
  logic        wr_w;
  pei_sel_t    sel_w;

  // ----------------------------------------------------------------
  // event sources into one vector, laid out as the flag register
  // ----------------------------------------------------------------
  // bit 8 stays zero here; it is built from the pin edges below
  always_comb begin
    raw_w                                       = 32'h00000000;
    raw_w[`PEI_BIT_PIN0+3:`PEI_BIT_PIN0]        = pin_event_in;
    raw_w[`PEI_BIT_IO_SUPPLY]                   = io_supply_good_in;
    raw_w[`PEI_BIT_ADC7:`PEI_BIT_ADC0]          = general_adc_event_in;
    raw_w[`PEI_BIT_FE_THERMAL]                  = front_end_thermal_warning_in;
    raw_w[`PEI_BIT_PMU_THERMAL]                 = pmu_thermal_warning_in;
    raw_w[`PEI_BIT_BATT_LOW]                    = battery_monitor_two_low_in;
    raw_w[`PEI_BIT_STANDBY_PREV]                = standby_prevent_in;
    raw_w[`PEI_BIT_LOW_POWER]                   = low_power_detect_in;
    raw_w[`PEI_BIT_BUS_POWER]                   = bus_power_present_in;
    raw_w[`PEI_BIT_TX_SUPPLY]                   = transmitter_supply_good_in;
    raw_w[`PEI_BIT_OVERCURRENT]                 = overcurrent_in;
    raw_w[`PEI_BIT_TX_REG_OC]                   = transmitter_regulator_overcurrent_in;
    raw_w[`PEI_BIT_SUSPEND_PREV]                = suspend_prevent_in;
    raw_w[`PEI_BIT_SUSPEND]                     = suspend_in;
  end

  // ----------------------------------------------------------------
  // two-flop synchroniser and edge history
  // ----------------------------------------------------------------
  // sync1_r feeds only sync2_r; edges are taken between sync2_r and prev_r
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_r <= 32'h00000000;
      sync2_r <= 32'h00000000;
      prev_r  <= 32'h00000000;
    end else begin
      sync1_r <= raw_w;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // rising edges everywhere; thermal bits and the transmitter supply-good bit fire on either edge
  assign edge_w = (sync2_r & ~prev_r) | ((sync2_r ^ prev_r) & `PEI_BOTH_EDGE_MASK);
  // common pin bit is the OR of the four pin edges; reserved bits never fire
  assign evt_w  = (edge_w | {23'h000000, |edge_w[3:0], 8'h00}) & `PEI_VALID_MASK;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // word index compare; the two low address bits are ignored
  always_comb begin
    unique case (paddr[`PEI_ADDR_W-1:2])
      `PEI_IDX_FLAG_SET:    sel_w = pei_sel_flag_set;
      `PEI_IDX_FLAG_CLEAR:  sel_w = pei_sel_flag_clear;
      `PEI_IDX_ENABLE_VIEW: sel_w = pei_sel_enable;
      `PEI_IDX_PENDING:     sel_w = pei_sel_pending;
      `PEI_IDX_MASK_SET:    sel_w = pei_sel_mask_set;
      `PEI_IDX_MASK_CLEAR:  sel_w = pei_sel_mask_clear;
      default:              sel_w = pei_sel_none;
    endcase
  end

  // read mux; write-only ports read as zero
  always_comb begin
    unique case (sel_w)
      pei_sel_enable:  rdata_w = en_r;
      pei_sel_pending: rdata_w = flag_r;
      default:         rdata_w = 32'h00000000;
    endcase
  end

  assign setup_w       = psel & ~penable;
  // a write lands only at the edge that completes the access phase
  assign wr_w          = psel & penable & pwrite & pready_r & ~pslverr_r;
  assign wdata_valid_w = pwdata & `PEI_VALID_MASK;
  assign clr_only_w    = wdata_valid_w & ~evt_w;

  // ----------------------------------------------------------------
  // apb answer: one wait-free access phase, all outputs registered
  // ----------------------------------------------------------------
  // the read value is captured in setup, so it may be one cycle older than the flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else if (setup_w) begin
      pready_r  <= 1'b1;
      pslverr_r <= (sel_w == pei_sel_none);
      prdata_r  <= pwrite ? 32'h00000000 : rdata_w;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // pending flags
  // ----------------------------------------------------------------
  // an event arriving with a clear of the same bit wins, so nothing is lost
  always_comb begin
    flag_nxt = flag_r;
    if (wr_w && sel_w == pei_sel_flag_clear) begin
      flag_nxt = flag_nxt & ~pwdata;
    end
    if (wr_w && sel_w == pei_sel_flag_set) begin
      flag_nxt = flag_nxt | pwdata;
    end
    flag_nxt = (flag_nxt | evt_w) & `PEI_VALID_MASK;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_r <= `PEI_PENDING_RESET;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ----------------------------------------------------------------
  // enable mask, changed only through its set and clear ports
  // ----------------------------------------------------------------
  always_comb begin
    en_nxt = en_r;
    if (wr_w && sel_w == pei_sel_mask_set) begin
      en_nxt = en_nxt | pwdata;
    end
    if (wr_w && sel_w == pei_sel_mask_clear) begin
      en_nxt = en_nxt & ~pwdata;
    end
    en_nxt = en_nxt & `PEI_VALID_MASK;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      en_r <= `PEI_ENABLE_RESET;
    end else begin
      en_r <= en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // registered, so irq follows the flags and mask one cycle later
  assign any_w = |(flag_r & en_r);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= any_w;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_apb_wr(logic [9:0] idx);
    psel && penable && pwrite && pready && paddr[`PEI_ADDR_W-1:2] == idx;
  endsequence

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  chk_enable_reset_zero: assert property (disable iff (1'b0) !rst_n |=> en_r == 32'h00000000 && !irq)
    else $error("enable mask not zero after reset");

  chk_pending_reset_zero: assert property (disable iff (1'b0) !rst_n |=> flag_r == 32'h00000000)
    else $error("pending flags not zero after reset");

  chk_pin_common_bit: assert property ((sync2_r[3:0] & ~prev_r[3:0]) != 4'h0 |=> flag_r[8])
    else $error("pin event did not raise common pin flag");

  chk_adc_bit_map: assert property (evt_w[16:9] != 8'h00 |=>
    (flag_r[16:9] & $past(evt_w[16:9])) == $past(evt_w[16:9]))
    else $error("adc event not on its flag bit");

  chk_pmu_thermal_edge: assert property (sync2_r[18] != prev_r[18] |=> flag_r[18])
    else $error("pmu thermal edge missed");

  chk_fe_thermal_edge: assert property (sync2_r[17] != prev_r[17] |=> flag_r[17])
    else $error("front end thermal edge missed");

  chk_standby_prev_bit: assert property ($rose(sync2_r[20]) |=> flag_r[20] ##1 flag_r[20])
    else $error("standby prevention flag not held");

  chk_reserved_zero: assert property (
    (flag_r & ~`PEI_VALID_MASK) == 32'h0 && (en_r & ~`PEI_VALID_MASK) == 32'h0)
    else $error("reserved bit set");

  chk_power_events: assert property (
    (sync2_r[30] && !prev_r[30]) || (sync2_r[23] && !prev_r[23]) |=> flag_r[30] || flag_r[23])
    else $error("power event flag missed");

  chk_flag_set_write: assert property (s_apb_wr(`PEI_IDX_FLAG_SET) |=>
    (flag_r & $past(wdata_valid_w)) == $past(wdata_valid_w))
    else $error("set-status write did not set flags");

  chk_flag_clear_write: assert property (s_apb_wr(`PEI_IDX_FLAG_CLEAR) |=>
    (flag_r & $past(clr_only_w)) == 32'h0)
    else $error("clear-status write did not clear flags");

  chk_mask_set_write: assert property (s_apb_wr(`PEI_IDX_MASK_SET) |=>
    (en_r & $past(wdata_valid_w)) == $past(wdata_valid_w))
    else $error("set-enable write did not set mask");

  chk_mask_clear_write: assert property (s_apb_wr(`PEI_IDX_MASK_CLEAR) |=> (en_r & $past(pwdata)) == 32'h0)
    else $error("clear-enable write did not clear mask");

  chk_irq_follows: assert property (##1 irq == $past(any_w))
    else $error("irq does not follow flags and mask");

  chk_apb_no_wait: assert property (s_apb_setup |=> pready ##1 !pready)
    else $error("apb answer not in one cycle");

endmodule : pei_power_event_irq

// ===== pei_cfg.svh
// Purpose: constants of the power event interrupt view (offsets, field positions, reset values)
// Assumes: included by bare name; holds definitions only
// Notes:   printed offsets are word indexes; byte address is four times the index
`ifndef PEI_CFG_SVH
`define PEI_CFG_SVH

// ----------------------------------------------------------------
// register indexes as printed, and the address width
// ----------------------------------------------------------------
`define PEI_ADDR_W           12
`define PEI_IDX_FLAG_SET     10'h0a1
`define PEI_IDX_FLAG_CLEAR   10'h0a2
`define PEI_IDX_ENABLE_VIEW  10'h0a3
`define PEI_IDX_PENDING      10'h0a4
`define PEI_IDX_MASK_SET     10'h0a5
`define PEI_IDX_MASK_CLEAR   10'h0a6

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PEI_BIT_PIN0         0
`define PEI_BIT_IO_SUPPLY    4
`define PEI_BIT_PIN_COMMON   8
`define PEI_BIT_ADC0         9
`define PEI_BIT_ADC7         16
`define PEI_BIT_FE_THERMAL   17
`define PEI_BIT_PMU_THERMAL  18
`define PEI_BIT_BATT_LOW     19
`define PEI_BIT_STANDBY_PREV 20
`define PEI_BIT_LOW_POWER    21
`define PEI_BIT_BUS_POWER    23
`define PEI_BIT_TX_SUPPLY    25
`define PEI_BIT_OVERCURRENT  26
`define PEI_BIT_TX_REG_OC    28
`define PEI_BIT_SUSPEND_PREV 29
`define PEI_BIT_SUSPEND      30

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define PEI_VALID_MASK       32'h76bfff1f
`define PEI_BOTH_EDGE_MASK   32'h02060000
`define PEI_ENABLE_RESET     32'h00000000
`define PEI_PENDING_RESET    32'h00000000

`endif

// ===== pei_pkg.sv
// Purpose: types of the power event interrupt view
// Assumes: nothing beyond the cfg header
// Notes:   register select enum used by the apb decode
package pei_pkg;

  // ----------------------------------------------------------------
  // decoded register select
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    pei_sel_none       = 3'b000,
    pei_sel_flag_set   = 3'b001,
    pei_sel_flag_clear = 3'b010,
    pei_sel_enable     = 3'b011,
    pei_sel_pending    = 3'b100,
    pei_sel_mask_set   = 3'b101,
    pei_sel_mask_clear = 3'b110
  } pei_sel_t;

endpackage : pei_pkg

// ===== power_event_irq_status_mask_tb_top.sv
// Purpose: self-checking bench of the power event interrupt view, driven over apb
// Assumes: one clock; event inputs are driven from one vector indexed by flag bit position
// Notes:   each scenario is a task; waits are bounded by a global cycle ceiling
`timescale 1ns/10ps
`include "pei_cfg.svh"

module power_event_irq_status_mask_tb_top
  import pei_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] A_SET  = {`PEI_IDX_FLAG_SET, 2'b00};
  localparam logic [11:0] A_CLR  = {`PEI_IDX_FLAG_CLEAR, 2'b00};
  localparam logic [11:0] A_EN   = {`PEI_IDX_ENABLE_VIEW, 2'b00};
  localparam logic [11:0] A_PEND = {`PEI_IDX_PENDING, 2'b00};
  localparam logic [11:0] A_MSET = {`PEI_IDX_MASK_SET, 2'b00};
  localparam logic [11:0] A_MCLR = {`PEI_IDX_MASK_CLEAR, 2'b00};
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, src;
  logic [31:0] rdat;
  logic        rerr;
  int          num_errors, cmp_count, cycles;

  pei_power_event_irq pei_power_event_irq_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_event_in(src[3:0]), .general_adc_event_in(src[16:9]),
    .front_end_thermal_warning_in(src[17]), .pmu_thermal_warning_in(src[18]),
    .battery_monitor_two_low_in(src[19]), .standby_prevent_in(src[20]),
    .low_power_detect_in(src[21]), .bus_power_present_in(src[23]),
    .transmitter_supply_good_in(src[25]), .overcurrent_in(src[26]),
    .transmitter_regulator_overcurrent_in(src[28]), .suspend_prevent_in(src[29]),
    .suspend_in(src[30]), .io_supply_good_in(src[4]), .irq(irq));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // the whole run needs under a thousand cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      $display("FAIL %0t timeout", $time);
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // compares and bus tasks
  // ----------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp, input string msg);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("FAIL %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : check_bit

  // setup, then access held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h00000000);
    check_word(rdat, exp, msg);
  endtask : rd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(A_EN, `PEI_ENABLE_RESET, "enable reset");
    rd(A_PEND, `PEI_PENDING_RESET, "pending reset");
    check_bit(irq, 1'b0, "irq after reset");
  endtask : t_reset

  // software set of every bit lands only on implemented flags
  task automatic t_soft_flags;
    apb(1'b1, A_SET, 32'hffffffff);
    rd(A_PEND, `PEI_VALID_MASK, "set all flags");
    apb(1'b1, A_PEND, 32'h00000000);
    rd(A_PEND, `PEI_VALID_MASK, "pending ignores write");
    apb(1'b1, A_CLR, 32'h00000000);
    rd(A_PEND, `PEI_VALID_MASK, "clear zero keeps");
    apb(1'b1, A_CLR, 32'h0000ff00);
    rd(A_PEND, 32'h76bf001f, "partial clear");
    apb(1'b1, A_CLR, 32'hffffffff);
    rd(A_PEND, 32'h00000000, "clear all");
    apb(1'b0, 12'hffc, 32'h00000000);
    check_bit(rerr, 1'b1, "unmapped error");
  endtask : t_soft_flags

  task automatic t_enable;
    apb(1'b1, A_MSET, 32'h12345a0f);
    rd(A_EN, 32'h12345a0f, "mask set");
    apb(1'b1, A_MSET, 32'h00000000);
    apb(1'b1, A_EN, 32'hffffffff);
    rd(A_EN, 32'h12345a0f, "zero and view ignored");
    apb(1'b1, A_MSET, 32'h40000000);
    apb(1'b1, A_MCLR, 32'h0000000f);
    rd(A_EN, 32'h52345a00, "mask clear part");
    apb(1'b1, A_MCLR, 32'hffffffff);
    rd(A_EN, 32'h00000000, "mask clear all");
  endtask : t_enable

  task automatic t_irq;
    apb(1'b1, A_SET, 32'h00080000);
    repeat (3) @(posedge clk_sys);
    check_bit(irq, 1'b0, "masked flag no irq");
    apb(1'b1, A_MSET, 32'h40000000);
    apb(1'b1, A_SET, 32'h40000000);
    repeat (3) @(posedge clk_sys);
    check_bit(irq, 1'b1, "enabled flag irq");
    apb(1'b1, A_MCLR, 32'h40000000);
    repeat (3) @(posedge clk_sys);
    check_bit(irq, 1'b0, "mask drops irq");
    apb(1'b1, A_MSET, 32'h40000000);
    repeat (3) @(posedge clk_sys);
    check_bit(irq, 1'b1, "sticky flag re-raises");
    apb(1'b1, A_CLR, 32'hffffffff);
    repeat (3) @(posedge clk_sys);
    check_bit(irq, 1'b0, "clear drops irq");
    apb(1'b1, A_MCLR, 32'hffffffff);
  endtask : t_irq

  // each source: rising edge, then falling edge; pins also raise the common bit
  task automatic t_events;
    logic [31:0] exp;
    for (int b = 0; b < 32; b++) begin
      if (`PEI_VALID_MASK & (32'h1 << b) & ~32'h00000100) begin
        src[b] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        exp = (32'h1 << b) | ((b < 4) ? 32'h00000100 : 32'h0);
        rd(A_PEND, exp, "rising event");
        apb(1'b1, A_CLR, 32'hffffffff);
        src[b] <= 1'b0;
        repeat (6) @(posedge clk_sys);
        exp = `PEI_BOTH_EDGE_MASK & (32'h1 << b);
        rd(A_PEND, exp, "falling event");
        apb(1'b1, A_CLR, 32'hffffffff);
      end
    end
  endtask : t_events

  // ----------------------------------------------------------------
  // closing report and main sequence
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    num_errors = 0;
    cmp_count  = 0;
    cycles     = 0;
    rst_n      = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h00000000;
    src        = 32'h00000000;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_soft_flags();
    t_enable();
    t_irq();
    t_events();
    end_sim();
  end
endmodule : power_event_irq_status_mask_tb_top
